// File: include/clamp_cfg_pkg.sv
// Constants for the drive clamp and resonance timing register slice.
// Assumes an 8-bit register port decoded by the serial control front end.
package clamp_cfg_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_STEADY_CLAMP    = 8'h24;
  localparam logic [7:0] ADDR_LOWBAT_FIRST    = 8'h25;
  localparam logic [7:0] ADDR_LOWBAT_SECOND   = 8'h26;
  localparam logic [7:0] ADDR_DRIVE_TIMING    = 8'h27;
  // Register holding loop gain and amplifier gain; offset is a local choice
  localparam logic [7:0] ADDR_FEEDBACK_CFG    = 8'h23;

  // Reset values
  localparam logic [7:0] RST_STEADY_CLAMP     = 8'h64;
  localparam logic [7:0] RST_LOWBAT_FIRST     = 8'h80;
  localparam logic [7:0] RST_LOWBAT_SECOND    = 8'h00;
  localparam logic [7:0] RST_DRIVE_TIMING     = 8'h10;
  localparam logic [7:0] RST_FEEDBACK_CFG     = 8'h06;

  // Field positions
  localparam int LOWEST_RES_BIT   = 7;
  localparam int RESYNC_BIT       = 6;
  localparam int RESERVED_BIT     = 5;
  localparam int DRIVE_TIME_MSB   = 4;
  localparam int LOOP_GAIN_MSB    = 3;
  localparam int LOOP_GAIN_LSB    = 2;
  localparam int AMP_GAIN_MSB     = 1;

  // Amplifier gain, x100, per actuator type and code
  localparam logic [11:0] GAIN_RES_X100 [4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
  localparam logic [11:0] GAIN_ROT_X100 [4] = '{12'h022, 12'h069, 12'h0B6, 12'h190};

  // Lowest resonance in Hz for each select value
  localparam logic [7:0] LOWEST_RES_HZ_0 = 8'h7D;
  localparam logic [7:0] LOWEST_RES_HZ_1 = 8'h2D;

endpackage

// File: design/clamp_min3.sv
// Lowest-of-three selector for the drive amplitude clamp.
// Purely combinational; the caller gates unused inputs to full scale.
`timescale 1ns/1ps
`default_nettype none
module clamp_min3 (
  input  wire logic [7:0] a_in,
  input  wire logic [7:0] b_in,
  input  wire logic [7:0] c_in,
  output logic      [7:0] min_out
);
  wire [7:0] ab = (a_in < b_in) ? a_in : b_in;
  assign min_out = (ab < c_in) ? ab : c_in;
endmodule
`default_nettype wire

// File: design/haptic_drive_clamp_config_regs.sv
// Clamp and resonance timing configuration bank with the resulting limit.
// Assumes a register port already decoded from the serial control link,
// and battery / calibration status levels synchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Amplifier gain code reads as 5/10/20/30x resonant or 0.34/1.05/1.82/4x rotating.
// - Calibration writes its chosen amplifier gain; software may overwrite later.
// - Steady drive limited by the rated clamp, reset 100, after overdrive ends.
// - Apply the lower of the active source (overdrive or low-battery clamp) and, outside overdrive, the rated clamp.
// - Below first battery threshold, first low-battery clamp replaces overdrive clamp.
// - Below second threshold, second clamp replaces overdrive and first clamps.
// - Calibration and diagnostics ignore both low-battery clamps.
// - Timing bit 7 picks lowest resonance: 0 is 125 Hz, 1 is 45 Hz.
// - Timing bit 6 picks resync basis: frequency select or drive time x1.25.
// - Loop gain bits 3-2 set settling speed, reset 1.
// - Drive time bits 4-0 give half-period guess or sample period, reset 16.
module haptic_drive_clamp_config_regs
  import clamp_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       clk_en,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  // Calibration gain update
  input  wire logic       cal_gain_wr,
  input  wire logic [1:0] cal_gain,
  // Operating status
  input  wire logic       rotating_mode,
  input  wire logic       overdrive_active,
  input  wire logic       cal_or_diag,
  input  wire logic       below_threshold_first,
  input  wire logic       below_threshold_second,
  input  wire logic [7:0] overdrive_limit,
  // Derived controls
  output logic      [7:0] drive_clamp,
  output logic     [11:0] amp_gain_x100,
  output logic      [1:0] loop_gain,
  output logic      [4:0] drive_time,
  output logic      [7:0] lowest_res_hz,
  output logic            resync_method_select
);

  logic [7:0] steady_clamp_r;
  logic [7:0] lowbat_first_r;
  logic [7:0] lowbat_second_r;
  logic [7:0] timing_r;
  logic [7:0] fb_cfg_r;
  logic [7:0] rdata_r;
  logic [7:0] clamp_r;
  logic [7:0] clamp_nxt;

  // Address decode shared by the write strobes and the read mux
  wire sel_steady = (reg_addr == ADDR_STEADY_CLAMP);
  wire sel_first  = (reg_addr == ADDR_LOWBAT_FIRST);
  wire sel_second = (reg_addr == ADDR_LOWBAT_SECOND);
  wire sel_timing = (reg_addr == ADDR_DRIVE_TIMING);
  wire sel_fb     = (reg_addr == ADDR_FEEDBACK_CFG);

  wire wr_steady = reg_wr && sel_steady;
  wire wr_first  = reg_wr && sel_first;
  wire wr_second = reg_wr && sel_second;
  wire wr_timing = reg_wr && sel_timing;
  wire wr_fb     = reg_wr && sel_fb;

  // Calibration and software write in one cycle: software wins, it came last
  wire [7:0] fb_wr_val = wr_fb ? reg_wdata :
                         {fb_cfg_r[7:AMP_GAIN_MSB+1], cal_gain};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      steady_clamp_r  <= RST_STEADY_CLAMP;
      lowbat_first_r  <= RST_LOWBAT_FIRST;
      lowbat_second_r <= RST_LOWBAT_SECOND;
      timing_r        <= RST_DRIVE_TIMING;
      fb_cfg_r        <= RST_FEEDBACK_CFG;
    end else if (clk_en) begin
      if (wr_steady) steady_clamp_r <= reg_wdata;
      if (wr_first) lowbat_first_r <= reg_wdata;
      if (wr_second) lowbat_second_r <= reg_wdata;
      if (wr_timing) timing_r <= reg_wdata;
      if (wr_fb || cal_gain_wr) fb_cfg_r <= fb_wr_val;
    end
  end

  // Read data
  wire [7:0] rd_mux =
    sel_steady ? steady_clamp_r  :
    sel_first  ? lowbat_first_r  :
    sel_second ? lowbat_second_r :
    sel_timing ? timing_r        :
    sel_fb     ? fb_cfg_r        : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) rdata_r <= 8'h00;
    else if (clk_en) rdata_r <= rd_mux;
  end
  assign reg_rdata = rdata_r;

  // Overdrive source: second level overrides first, both dropped in cal
  // Battery flags are taken as levels; the monitor must filter them
  wire lowbat_ok = !cal_or_diag;
  wire [7:0] od_src =
    (lowbat_ok && below_threshold_second) ? lowbat_second_r :
    (lowbat_ok && below_threshold_first)  ? lowbat_first_r  :
    overdrive_limit;

  // Rated clamp only bounds the steady part; full scale while overdriving
  wire [7:0] steady_term = overdrive_active ? 8'hFF : steady_clamp_r;

  clamp_min3 u_min (
    .a_in    (od_src),
    .b_in    (steady_term),
    .c_in    (8'hFF),
    .min_out (clamp_nxt)
  );

  // Registered so the clamp cannot glitch while the battery flags move

  always_ff @(posedge sys_clk) begin
    if (rst) clamp_r <= RST_STEADY_CLAMP;
    else if (clk_en) clamp_r <= clamp_nxt;
  end
  assign drive_clamp = clamp_r;

  // Field decodes
  wire [1:0] gain_code = fb_cfg_r[AMP_GAIN_MSB:0];
  assign amp_gain_x100 = rotating_mode ? GAIN_ROT_X100[gain_code]
                                       : GAIN_RES_X100[gain_code];
  assign loop_gain = fb_cfg_r[LOOP_GAIN_MSB:LOOP_GAIN_LSB];
  assign drive_time = timing_r[DRIVE_TIME_MSB:0];
  assign lowest_res_hz = timing_r[LOWEST_RES_BIT] ? LOWEST_RES_HZ_1
                                                  : LOWEST_RES_HZ_0;
  assign resync_method_select = timing_r[RESYNC_BIT];

  // Assertions
  // Sources are sampled at the launching edge; a same-edge write lands after
  sequence s_timing_write;
    clk_en && wr_timing;
  endsequence
  sequence s_timing_read;
    clk_en && reg_addr == ADDR_DRIVE_TIMING;
  endsequence

  a_rst_values: assert property (
    @(posedge sys_clk) rst |=> drive_clamp == RST_STEADY_CLAMP && reg_rdata == 8'h00)
    else $error("reset values wrong");

  a_clamp_not_above: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && !overdrive_active |=> drive_clamp <= $past(steady_clamp_r))
    else $error("clamp above rated value");
  a_clamp_lowest: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en |=> drive_clamp <= $past(od_src))
    else $error("clamp not lowest");
  // Result must be one of the candidates, not merely below them
  a_clamp_reaches: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en |=> drive_clamp == $past(od_src) || drive_clamp == $past(steady_term))
    else $error("clamp is not a candidate value");
  a_second_used: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && lowbat_ok && below_threshold_second && overdrive_active
    |=> drive_clamp == $past(lowbat_second_r))
    else $error("second clamp not applied");
  a_first_used: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && lowbat_ok && below_threshold_first && !below_threshold_second
    && overdrive_active |=> drive_clamp == $past(lowbat_first_r))
    else $error("first clamp not applied");
  a_cal_ignores: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && cal_or_diag && overdrive_active
    |=> drive_clamp == $past(overdrive_limit))
    else $error("low battery clamp used in calibration");

  a_cal_gain: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && cal_gain_wr && !wr_fb |=> gain_code == $past(cal_gain))
    else $error("calibration gain not stored");
  a_sw_gain_wins: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && cal_gain_wr && wr_fb |=> fb_cfg_r == $past(reg_wdata))
    else $error("software write lost to calibration");
  a_min_freq: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && wr_timing |=> lowest_res_hz ==
    ($past(reg_wdata[LOWEST_RES_BIT]) ? LOWEST_RES_HZ_1 : LOWEST_RES_HZ_0))
    else $error("lowest resonance wrong");
  a_resync_sel: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && wr_timing |=> resync_method_select == $past(reg_wdata[RESYNC_BIT]))
    else $error("resync select wrong");
  a_loop_gain_wr: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && wr_fb |=> loop_gain == $past(reg_wdata[LOOP_GAIN_MSB:LOOP_GAIN_LSB]))
    else $error("loop gain not stored");
  a_drive_time_wr: assert property (
    @(posedge sys_clk) disable iff (rst)
    clk_en && wr_timing |=> drive_time == $past(reg_wdata[DRIVE_TIME_MSB:0]))
    else $error("drive time not stored");
  a_reserved_back: assert property (
    @(posedge sys_clk) disable iff (rst)
    s_timing_write ##1 s_timing_read
    |=> reg_rdata[RESERVED_BIT] == $past(reg_wdata[RESERVED_BIT], 2))
    else $error("reserved bit not read back");

  a_gain_decode: assert property (
    @(posedge sys_clk) disable iff (rst)
    gain_code == 2'h0 && !rotating_mode |-> amp_gain_x100 == 12'h1F4)
    else $error("gain decode wrong");
  a_gain_rotating: assert property (
    @(posedge sys_clk) disable iff (rst)
    gain_code == 2'h3 && rotating_mode |-> amp_gain_x100 == 12'h190)
    else $error("rotating gain decode wrong");

endmodule
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the clamp and drive timing register slice.
// Assumes registered read data one cycle after the address and one-cycle writes.
`timescale 1ns/1ps
`default_nettype none
module testbench import clamp_cfg_pkg::*;;
  logic        sys_clk = 0, rst = 1, clk_en = 1, reg_wr = 0, cal_gain_wr = 0;
  logic        rotating_mode = 0, overdrive_active = 0, cal_or_diag = 0;
  logic        below_threshold_first = 0, below_threshold_second = 0;
  logic [7:0]  reg_addr = 0, reg_wdata = 0, overdrive_limit = 0, reg_rdata, drive_clamp;
  logic [7:0]  lowest_res_hz, a;
  logic [1:0]  cal_gain = 0, loop_gain;
  logic [4:0]  drive_time;
  logic [11:0] amp_gain_x100;
  logic        resync_method_select;
  logic [31:0] lfsr = 32'hEB90, r;
  logic [7:0]  m [8'h23:8'h27];
  int          error_cnt = 0, total_checks = 0;

  haptic_drive_clamp_config_regs i_haptic_drive_clamp_config_regs (.sys_clk, .rst, .clk_en,
    .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .cal_gain_wr, .cal_gain, .rotating_mode,
    .overdrive_active, .cal_or_diag, .below_threshold_first, .below_threshold_second,
    .overdrive_limit, .drive_clamp, .amp_gain_x100, .loop_gain, .drive_time, .lowest_res_hz,
    .resync_method_select);

  always #50 sys_clk = ~sys_clk;

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  // Second threshold outranks the first; calibration hides both
  function automatic logic [7:0] exp_clamp();
    logic [7:0] s, c;
    s = (below_threshold_second && !cal_or_diag) ? m[8'h26] :
        (below_threshold_first && !cal_or_diag) ? m[8'h25] : overdrive_limit;
    c = overdrive_active ? 8'hFF : m[8'h24];
    return (s < c) ? s : c;
  endfunction

  function automatic logic [11:0] exp_gain(input logic rot, input logic [1:0] code);
    return rot ? GAIN_ROT_X100[code] : GAIN_RES_X100[code];
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 0;
    if (clk_en && ad >= 8'h23 && ad <= 8'h27) m[ad] = d;
  endtask

  task automatic chkrd(input logic [7:0] ad);
    @(posedge sys_clk);
    clk_en <= 1;
    reg_addr <= ad;
    @(posedge sys_clk);
    #1 chk(reg_rdata, (ad >= 8'h23 && ad <= 8'h27) ? m[ad] : 8'h00);
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    m = '{8'h06, 8'h64, 8'h80, 8'h00, 8'h10};
    for (int i = 8'h23; i <= 8'h28; i++) chkrd(i[7:0]);
    chk(loop_gain, 2'h1);
    chk(amp_gain_x100, 12'h7D0);
    $display("reset values done");
    // Code 5 also carries a software write to the same register, which must win
    for (int g = 0; g < 8; g++) begin
      @(posedge sys_clk);
      cal_gain_wr <= 1;
      cal_gain <= g[1:0];
      rotating_mode <= g[2];
      reg_wr <= (g == 5);
      reg_addr <= 8'h23;
      reg_wdata <= 8'hA7;
      @(posedge sys_clk);
      cal_gain_wr <= 0;
      reg_wr <= 0;
      m[8'h23] = (g == 5) ? 8'hA7 : {m[8'h23][7:2], g[1:0]};
      #1 chk(amp_gain_x100, exp_gain(g[2], m[8'h23][1:0]));
    end
    $display("gain codes done");
    // Random writes, some with the clock enable low, across the map and one hole
    repeat (40) begin
      r = rnd();
      @(posedge sys_clk);
      clk_en <= r[8] | r[9];
      rotating_mode <= r[10];
      a = 8'h23 + 8'(r[18:16] % 3'h6);
      wr(a, r[7:0]);
      chkrd(a);
      chk(drive_time, m[8'h27][4:0]);
      chk(resync_method_select, m[8'h27][6]);
      chk(lowest_res_hz, m[8'h27][7] ? 8'h2D : 8'h7D);
      chk(loop_gain, m[8'h23][3:2]);
      chk(amp_gain_x100, exp_gain(rotating_mode, m[8'h23][1:0]));
    end
    $display("register access done");
    repeat (40) begin
      r = rnd();
      wr(8'h24, r[7:0]);
      wr(8'h25, r[15:8]);
      wr(8'h26, r[23:16]);
      r = rnd();
      @(posedge sys_clk);
      {overdrive_active, cal_or_diag, below_threshold_first, below_threshold_second} <= r[3:0];
      overdrive_limit <= r[15:8];
      repeat (2) @(posedge sys_clk);
      #1 chk(drive_clamp, exp_clamp());
    end
    $display("clamp selection done");
    end_of_test();
  end

  initial begin
    #500000;
    error_cnt++;
    end_of_test();
  end
endmodule
`default_nettype wire
